//--- rtl/accel_irq_out_stage.sv
/*
 * Interrupt output stage with low-g, high-g, any-motion and slow/no-motion engines.
 * Assumes samples, slopes and external settings arrive on the same clock,
 * and register accesses come from the serial interface as single-cycle strobes.
 */
// Summary of operation
// - Drive bit picks push-pull or open-drain per pin
// - Polarity bit picks active level; reset high push-pull
// - Writing clear bit one drops all latched interrupts except those rising in that cycle
// - Codes 0000/1000 non-latched, 0111/1111 fully latched
// - Other codes give temporary hold times
// - Low-g waits (duration+1) times 2 ms
// - Low-g threshold is field times 7.81 mg
// - Low-g per-axis or axis-sum by mode bit
// - Low-g hysteresis is field times 125 mg
// - High-g hysteresis step scales with range
// - High-g waits (duration+1) times 2 ms
// - High-g threshold step scales with range
// - Any-motion needs duration+1 consecutive slopes above
// - Slow-motion needs duration+1 consecutive slopes above
// - No-motion waits a quiet time from field
// - Select bit picks slow or no motion
`timescale 1ns/1ps
module accel_irq_out_stage
  import accel_irq_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire accel_sample_t accel_in,
  input  wire slope_sample_t slope_in,
  input  wire ext_cfg_t      ext_cfg_in,
  output logic [7:0]         reg_rdata_out,
  output logic [NUM_ENG-1:0] int_status_out,
  output logic               irq_pin_a_out,
  output logic               irq_pin_a_oe_out,
  output logic               irq_pin_b_out,
  output logic               irq_pin_b_oe_out
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Magnitude of a signed sample
  function automatic logic [13:0] mag(input logic signed [11:0] v);
    logic [11:0] u;
    u = v[11] ? 12'(-v) : 12'(v);
    mag = {2'b00, u};
  endfunction

  // Kind of latching from the mode code
  function automatic latch_kind_t kind_of(input logic [3:0] code);
    kind_of = LK_TEMP;
    if (code[2:0] == 3'b000) begin
      kind_of = LK_NONE;
    end else if (code[2:0] == 3'b111) begin
      kind_of = LK_HOLD;
    end
  endfunction

  // Temporary hold time in ticks
  function automatic logic [15:0] hold_ticks(input logic [3:0] code);
    logic [15:0] t;
    t = 16'h0001;
    unique case (code)
      4'h1:    t = 16'h03E8;                      // 250 ms
      4'h2:    t = 16'h07D0;                      // 500 ms
      4'h3:    t = 16'h0FA0;                      // 1 s
      4'h4:    t = 16'h1F40;                      // 2 s
      4'h5:    t = 16'h3E80;                      // 4 s
      4'h6:    t = 16'h7D00;                      // 8 s
      4'h9:    t = 16'h0001;                      // 250 us
      4'hA:    t = 16'h0002;                      // 500 us
      4'hB:    t = 16'h0004;                      // 1 ms
      4'hC:    t = 16'h0032;                      // 12.5 ms
      4'hD:    t = 16'h0064;                      // 25 ms
      4'hE:    t = 16'h00C8;                      // 50 ms
      default: t = 16'h0001;
    endcase
    hold_ticks = t;
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] pin_cfg_r;
  logic [7:0] latch_r;
  logic [7:0] lowg_dly_r;
  logic [7:0] lowg_lvl_r;
  logic [7:0] hyst_mode_r;
  logic [7:0] highg_dly_r;
  logic [7:0] highg_lvl_r;
  logic [7:0] mot_dur_r;
  logic       clear_req;

  // Writes keep only the stored bits
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_cfg_r   <= RST_PIN_CFG;
      latch_r     <= RST_LATCH;
      lowg_dly_r  <= RST_LOWG_DLY;
      lowg_lvl_r  <= RST_LOWG_LVL;
      hyst_mode_r <= RST_HYST_MODE;
      highg_dly_r <= RST_HIGHG_DLY;
      highg_lvl_r <= RST_HIGHG_LVL;
      mot_dur_r   <= RST_MOT_DUR;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_PIN_CFG:   pin_cfg_r   <= reg_wdata_in & PIN_CFG_MASK;
        ADDR_LATCH:     latch_r     <= reg_wdata_in & LATCH_MASK;
        ADDR_LOWG_DLY:  lowg_dly_r  <= reg_wdata_in;
        ADDR_LOWG_LVL:  lowg_lvl_r  <= reg_wdata_in;
        ADDR_HYST_MODE: hyst_mode_r <= reg_wdata_in & HYST_MASK;
        ADDR_HIGHG_DLY: highg_dly_r <= reg_wdata_in;
        ADDR_HIGHG_LVL: highg_lvl_r <= reg_wdata_in;
        ADDR_MOT_DUR:   mot_dur_r   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Write-only clear bit acts in the write cycle
  assign clear_req = reg_wr_in && (reg_addr_in == ADDR_LATCH)
                     && reg_wdata_in[CLEAR_BIT];

  // Read port; clear bit and unmapped offsets read zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_PIN_CFG:   reg_rdata_out <= pin_cfg_r;
        ADDR_LATCH:     reg_rdata_out <= latch_r;
        ADDR_LOWG_DLY:  reg_rdata_out <= lowg_dly_r;
        ADDR_LOWG_LVL:  reg_rdata_out <= lowg_lvl_r;
        ADDR_HYST_MODE: reg_rdata_out <= hyst_mode_r;
        ADDR_HIGHG_DLY: reg_rdata_out <= highg_dly_r;
        ADDR_HIGHG_LVL: reg_rdata_out <= highg_lvl_r;
        ADDR_MOT_DUR:   reg_rdata_out <= mot_dur_r;
        default:        reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Time base
  // ************************************************************
  logic [15:0] tick_cnt_r;
  logic        tick;

  // One tick every 250 us
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= 16'h0000;
    end else if (tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

  // ************************************************************
  // Acceleration thresholds in raw counts
  // ************************************************************
  logic [13:0] ax;
  logic [13:0] ay;
  logic [13:0] az;
  logic [13:0] asum;
  logic [13:0] lowg_level;
  logic [13:0] low_rel;
  logic [13:0] highg_level;
  logic [13:0] high_rel;
  logic [13:0] highg_hysteresis;

  assign ax       = mag(accel_in.x);
  assign ay       = mag(accel_in.y);
  assign az       = mag(accel_in.z);
  assign asum     = ax + ay + az;
  // Fixed mg steps shrink in counts as the range widens
  assign lowg_level   = {3'b000, lowg_lvl_r, 3'b000} >> ext_cfg_in.range;
  assign low_rel  = lowg_level + (14'({hyst_mode_r[LOWG_HY_LSB +: 2], 7'h00})
                    >> ext_cfg_in.range);
  // Range-scaled steps are constant in counts
  assign highg_level  = {3'b000, highg_lvl_r, 3'b000};
  assign highg_hysteresis  = {5'h00, hyst_mode_r[HIGHG_HY_LSB +: 2], 7'h00};
  assign high_rel = (highg_level > highg_hysteresis) ? highg_level - highg_hysteresis : 14'h0000;

  // ************************************************************
  // Low-g and high-g conditions
  // ************************************************************
  logic [1:0] g_on;
  logic [1:0] g_off;
  logic [2:0] hi_ax;
  logic [2:0] hi_rel_ax;

  assign hi_ax     = {az > highg_level, ay > highg_level, ax > highg_level} & ext_cfg_in.highg_axis_en;
  assign hi_rel_ax = {az >= high_rel, ay >= high_rel, ax >= high_rel}
                     & ext_cfg_in.highg_axis_en;

  // Condition to enter and to leave each engine
  always_comb begin
    if (hyst_mode_r[LOWG_MODE_BIT]) begin
      g_on[ENG_LOWG]  = asum < lowg_level;
      g_off[ENG_LOWG] = asum >= low_rel;
    end else begin
      g_on[ENG_LOWG]  = (ax < lowg_level) || (ay < lowg_level) || (az < lowg_level);
      g_off[ENG_LOWG] = (ax >= low_rel) && (ay >= low_rel) && (az >= low_rel);
    end
    g_on[ENG_HIGHG]  = |hi_ax;
    g_off[ENG_HIGHG] = ~|hi_rel_ax;
  end

  // ************************************************************
  // Low-g and high-g engines
  // ************************************************************
  logic [1:0]  g_active;
  logic [11:0] g_need [2];

  assign g_need[ENG_LOWG]  = 12'(({4'h0, lowg_dly_r} + 12'h001) * TICKS_PER_STEP);
  assign g_need[ENG_HIGHG] = 12'(({4'h0, highg_dly_r} + 12'h001) * TICKS_PER_STEP);

  for (genvar g = 0; g < 2; g++) begin : gen_g
    g_state_t    st_r;
    logic [11:0] cnt_r;

    // Condition must hold for the whole delay before activating
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        st_r  <= G_IDLE;
        cnt_r <= 12'h000;
      end else begin
        unique case (st_r)
          G_IDLE: begin
            cnt_r <= 12'h000;
            if (accel_in.valid && g_on[g]) begin
              st_r <= G_QUAL;
            end
          end
          G_QUAL: begin
            if (accel_in.valid && !g_on[g]) begin
              st_r <= G_IDLE;
            end else if (cnt_r >= g_need[g]) begin
              st_r <= G_ACTIVE;
            end else if (tick) begin
              cnt_r <= cnt_r + 12'h001;
            end
          end
          G_ACTIVE: begin
            if (accel_in.valid && g_off[g]) begin
              st_r <= G_IDLE;
            end
          end
          default: st_r <= G_IDLE;
        endcase
      end
    end
    assign g_active[g] = (st_r == G_ACTIVE);
  end

  // ************************************************************
  // Slope engines
  // ************************************************************
  logic [13:0] any_lvl;
  logic [13:0] still_lvl;
  logic        any_over;
  logic        still_over;
  logic [2:0]  any_cnt_r;
  logic [2:0]  still_cnt_r;
  logic [20:0] quiet_r;
  logic [20:0] quiet_need;
  logic [8:0]  quiet_sec;
  logic [5:0]  still_dur;

  // Slope steps are range-scaled, so constant in counts
  assign any_lvl    = {4'h0, ext_cfg_in.anymotion_level, 2'b00};
  assign still_lvl  = {4'h0, ext_cfg_in.stillness_level, 2'b00};
  assign any_over   = |({slope_in.z > any_lvl[11:0], slope_in.y > any_lvl[11:0],
                         slope_in.x > any_lvl[11:0]} & ext_cfg_in.anymot_axis_en);
  assign still_over = |({slope_in.z > still_lvl[11:0], slope_in.y > still_lvl[11:0],
                         slope_in.x > still_lvl[11:0]} & ext_cfg_in.still_axis_en);
  assign still_dur  = mot_dur_r[STILL_DUR_LSB +: 6];

  // Quiet time in seconds from the duration field
  always_comb begin
    if (still_dur[5]) begin
      quiet_sec = 9'({still_dur[4:0], 3'b000}) + 9'(NOMOT_BASE2_S);
    end else if (still_dur[4]) begin
      quiet_sec = 9'({still_dur[3:0], 2'b00}) + 9'(NOMOT_BASE1_S);
    end else begin
      quiet_sec = 9'(still_dur[3:0]) + 9'h001;
    end
    quiet_need = 21'(quiet_sec * TICKS_PER_SEC);
  end

  // Runs of slope samples above each threshold, saturating
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      any_cnt_r   <= 3'h0;
      still_cnt_r <= 3'h0;
    end else if (slope_in.valid) begin
      any_cnt_r   <= !any_over ? 3'h0 : (any_cnt_r[2] ? any_cnt_r : any_cnt_r + 3'h1);
      still_cnt_r <= !still_over ? 3'h0 : (still_cnt_r[2] ? still_cnt_r : still_cnt_r + 3'h1);
    end
  end

  // Time since the last slope above the stillness level
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_r <= 21'h000000;
    end else if (slope_in.valid && still_over) begin
      quiet_r <= 21'h000000;
    end else if (tick && quiet_r < quiet_need) begin
      quiet_r <= quiet_r + 21'h000001;
    end
  end

  // ************************************************************
  // Engine levels
  // ************************************************************
  logic [NUM_ENG-1:0] eng_active;
  logic [NUM_ENG-1:0] eng_prev_r;

  assign eng_active[ENG_LOWG]   = g_active[ENG_LOWG];
  assign eng_active[ENG_HIGHG]  = g_active[ENG_HIGHG];
  assign eng_active[ENG_ANYMOT] = any_cnt_r >= 3'(mot_dur_r[ANYMOT_DUR_LSB +: 2]) + 3'h1;
  assign eng_active[ENG_STILL]  = ext_cfg_in.still_sel ?
                                  (quiet_r >= quiet_need) :
                                  (still_cnt_r >= 3'(mot_dur_r[STILL_DUR_LSB +: 2]) + 3'h1);

  // Previous level for rise detection
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eng_prev_r <= '0;
    end else begin
      eng_prev_r <= eng_active;
    end
  end

  // ************************************************************
  // Latching per engine
  // ************************************************************
  latch_kind_t        lk;
  logic [15:0]        hold_len;
  logic [NUM_ENG-1:0] state_r;

  assign lk       = kind_of(latch_r[3:0]);
  assign hold_len = hold_ticks(latch_r[3:0]);

  for (genvar e = 0; e < NUM_ENG; e++) begin : gen_latch
    logic [15:0] hold_r;
    logic        rise;

    assign rise = eng_active[e] && !eng_prev_r[e];

    // A new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        state_r[e] <= 1'b0;
        hold_r     <= 16'h0000;
      end else begin
        unique case (lk)
          LK_NONE: begin
            state_r[e] <= eng_active[e];
            hold_r     <= 16'h0000;
          end
          LK_HOLD: begin
            if (rise) begin
              state_r[e] <= 1'b1;
            end else if (clear_req) begin
              state_r[e] <= 1'b0;
            end
          end
          LK_TEMP: begin
            if (rise) begin
              state_r[e] <= 1'b1;
              hold_r     <= hold_len;
            end else if (clear_req) begin
              state_r[e] <= 1'b0;
              hold_r     <= 16'h0000;
            end else if (tick && state_r[e]) begin
              if (hold_r <= 16'h0001) begin
                state_r[e] <= 1'b0;
                hold_r     <= 16'h0000;
              end else begin
                hold_r     <= hold_r - 16'h0001;
              end
            end
          end
          default: state_r[e] <= 1'b0;
        endcase
      end
    end
  end

  // Status copy for the outside
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_status_out <= '0;
    end else begin
      int_status_out <= state_r;
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  logic [1:0] pin_level;
  logic [1:0] pin_o;
  logic [1:0] pin_oe;
  logic [1:0] pin_pol;
  logic [1:0] pin_drv;

  assign pin_level = {|(state_r & ext_cfg_in.map_b), |(state_r & ext_cfg_in.map_a)};
  assign pin_pol   = {pin_cfg_r[PIN_B_POL_BIT], pin_cfg_r[PIN_A_POL_BIT]};
  assign pin_drv   = {pin_cfg_r[PIN_B_DRV_BIT], pin_cfg_r[PIN_A_DRV_BIT]};

  for (genvar p = 0; p < 2; p++) begin : gen_pin
    accel_irq_pin_drv u_drv (
      .ref_clk_in    (ref_clk_in),
      .rst_n_in      (rst_n_in),
      .assert_in     (pin_level[p]),
      .polarity_in   (pin_pol[p]),
      .drive_type_in (pin_drv[p]),
      .pin_out       (pin_o[p]),
      .pin_oe_out    (pin_oe[p])
    );
  end

  assign irq_pin_a_out    = pin_o[0];
  assign irq_pin_a_oe_out = pin_oe[0];
  assign irq_pin_b_out    = pin_o[1];
  assign irq_pin_b_oe_out = pin_oe[1];

endmodule

//--- rtl/accel_irq_pkg.sv
/*
 * Shared constants and types of the accelerometer interrupt output stage.
 * Assumes one 50 MHz clock and an 8-bit register port from the serial interface.
 */
package accel_irq_pkg;

  // ************************************************************
  // Register offsets and reset values
  // ************************************************************
  localparam logic [7:0] ADDR_PIN_CFG   = 8'h20;
  localparam logic [7:0] ADDR_LATCH     = 8'h21;
  localparam logic [7:0] ADDR_LOWG_DLY  = 8'h22;
  localparam logic [7:0] ADDR_LOWG_LVL  = 8'h23;
  localparam logic [7:0] ADDR_HYST_MODE = 8'h24;
  localparam logic [7:0] ADDR_HIGHG_DLY = 8'h25;
  localparam logic [7:0] ADDR_HIGHG_LVL = 8'h26;
  localparam logic [7:0] ADDR_MOT_DUR   = 8'h27;

  localparam logic [7:0] RST_PIN_CFG    = 8'h05;
  localparam logic [7:0] RST_LATCH      = 8'h00;
  localparam logic [7:0] RST_LOWG_DLY   = 8'h09;
  localparam logic [7:0] RST_LOWG_LVL   = 8'h30;
  localparam logic [7:0] RST_HYST_MODE  = 8'h81;
  localparam logic [7:0] RST_HIGHG_DLY  = 8'h0F;
  localparam logic [7:0] RST_HIGHG_LVL  = 8'hC0;
  localparam logic [7:0] RST_MOT_DUR    = 8'h00;

  // ************************************************************
  // Field positions and stored-bit masks
  // ************************************************************
  localparam int         PIN_A_POL_BIT  = 0;
  localparam int         PIN_A_DRV_BIT  = 1;
  localparam int         PIN_B_POL_BIT  = 2;
  localparam int         PIN_B_DRV_BIT  = 3;
  localparam int         CLEAR_BIT      = 7;
  localparam int         LOWG_MODE_BIT  = 2;
  localparam int         LOWG_HY_LSB    = 0;
  localparam int         HIGHG_HY_LSB   = 6;
  localparam int         ANYMOT_DUR_LSB = 0;
  localparam int         STILL_DUR_LSB  = 2;
  localparam logic [7:0] PIN_CFG_MASK   = 8'h0F;
  localparam logic [7:0] LATCH_MASK     = 8'h0F;
  localparam logic [7:0] HYST_MASK      = 8'hC7;

  // ************************************************************
  // Timing: one tick is 250 us, all holds and delays count ticks
  // ************************************************************
  localparam int CLK_FREQ_MHZ   = 50;
  localparam int TICK_US        = 250;
  localparam int TICK_CYCLES    = TICK_US * CLK_FREQ_MHZ;
  localparam int DELAY_STEP_US  = 2000;
  localparam int TICKS_PER_STEP = DELAY_STEP_US / TICK_US;
  localparam int TICKS_PER_SEC  = 1000000 / TICK_US;
  localparam int NOMOT_BASE1_S  = 20;
  localparam int NOMOT_BASE2_S  = 88;

  // Engine slots in the status vector
  localparam int ENG_LOWG   = 0;
  localparam int ENG_HIGHG  = 1;
  localparam int ENG_ANYMOT = 2;
  localparam int ENG_STILL  = 3;
  localparam int NUM_ENG    = 4;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    LK_NONE = 2'b00,
    LK_TEMP = 2'b01,
    LK_HOLD = 2'b11
  } latch_kind_t;

  typedef enum logic [1:0] {
    G_IDLE   = 2'b00,
    G_QUAL   = 2'b01,
    G_ACTIVE = 2'b11
  } g_state_t;

  typedef struct packed {
    logic               valid;
    logic signed [11:0] x;
    logic signed [11:0] y;
    logic signed [11:0] z;
  } accel_sample_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } slope_sample_t;

  typedef struct packed {
    logic [1:0] range;
    logic [2:0] highg_axis_en;
    logic [2:0] anymot_axis_en;
    logic       still_sel;
    logic [2:0] still_axis_en;
    logic [7:0] anymotion_level;
    logic [7:0] stillness_level;
    logic [3:0] map_a;
    logic [3:0] map_b;
  } ext_cfg_t;

endpackage

//--- rtl/accel_irq_pin_drv.sv
/*
 * One interrupt pin output stage: polarity and push-pull or open-drain drive.
 * Assumes the wire level is resolved outside from pin_out and pin_oe_out.
 */
`timescale 1ns/1ps
module accel_irq_pin_drv (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic assert_in,
  input  wire logic polarity_in,
  input  wire logic drive_type_in,
  output logic      pin_out,
  output logic      pin_oe_out
);

  logic level;

  // Electrical level for the asserted state
  assign level = polarity_in ? assert_in : ~assert_in;

  // ************************************************************
  // Registered driver
  // ************************************************************
  // Reset shows an idle active-high push-pull pin
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out    <= 1'b0;
      pin_oe_out <= 1'b1;
    end else if (drive_type_in) begin
      pin_out    <= 1'b0;
      pin_oe_out <= ~level;
    end else begin
      pin_out    <= level;
      pin_oe_out <= 1'b1;
    end
  end

endmodule

//--- sim/accel_irq_host_model.sv
/* Host side of the two interrupt wires: each wire carries a pull-up.
   Assumes pin value and enable come straight from the device outputs. */
`timescale 1ns/1ps
module accel_irq_host_model (
  input  wire logic pin_a_in,
  input  wire logic pin_a_oe_in,
  input  wire logic pin_b_in,
  input  wire logic pin_b_oe_in,
  output logic      level_a_out,
  output logic      level_b_out
);
  // Released wire rises to the pull-up level
  assign level_a_out = pin_a_oe_in ? pin_a_in : 1'b1;
  assign level_b_out = pin_b_oe_in ? pin_b_in : 1'b1;
endmodule

//--- sim/accel_irq_out_stage_sva.sv
/* Port checker of the interrupt output stage.
   Assumes single-cycle register strobes and registered pins. */
`timescale 1ns/1ps
module accel_irq_chk
  import accel_irq_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [3:0] int_status_out,
  input wire logic       irq_pin_a_out,
  input wire logic       irq_pin_a_oe_out,
  input wire logic       irq_pin_b_out,
  input wire logic       irq_pin_b_oe_out
);
  logic [3:0] cfg_r;
  logic [3:0] lat_r;
  logic       w21;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  assign w21 = reg_wr_in && reg_addr_in == ADDR_LATCH;
  // Shadow of pin set-up and latch mode
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r <= RST_PIN_CFG[3:0];
      lat_r <= RST_LATCH[3:0];
    end else begin
      if (reg_wr_in && reg_addr_in == ADDR_PIN_CFG) cfg_r <= reg_wdata_in[3:0];
      if (w21) lat_r <= reg_wdata_in[3:0];
    end
  end
  a_pin_a_pp:
    assert property ($stable(cfg_r) && !cfg_r[1] |-> irq_pin_a_oe_out) else $error("pin a not driven");
  a_pin_a_od:
    assert property ($stable(cfg_r) && cfg_r[1] |-> !irq_pin_a_out) else $error("pin a drives high");
  a_pin_b_pp:
    assert property ($stable(cfg_r) && !cfg_r[3] |-> irq_pin_b_oe_out) else $error("pin b not driven");
  a_pin_b_od:
    assert property ($stable(cfg_r) && cfg_r[3] |-> !irq_pin_b_out) else $error("pin b drives high");
  a_clear_drops:
    assert property (w21 && reg_wdata_in[7] && lat_r[2:0] != 3'h0 && reg_wdata_in[2:0] != 3'h0
      |-> ##2 int_status_out == 4'h0) else $error("clear left status set");
  a_latch_holds:
    assert property ($past(lat_r[2:0]) == 3'h7 && !$past(w21)
      |=> (~int_status_out & $past(int_status_out)) == 4'h0) else $error("latched status fell");
  a_cfg_read:
    assert property (reg_rd_in && reg_addr_in == ADDR_PIN_CFG |=> reg_rdata_out == {4'h0, $past(cfg_r)})
      else $error("pin set-up readback");
  a_latch_read:
    assert property (reg_rd_in && reg_addr_in == ADDR_LATCH |=> reg_rdata_out == {4'h0, $past(lat_r)})
      else $error("latch readback");
  c_clear: cover property (w21 && reg_wdata_in[7]);
  c_rise: cover property ($rose(int_status_out[ENG_LOWG]));
  c_release: cover property (cfg_r[1] && !irq_pin_a_oe_out);
endmodule
bind accel_irq_out_stage accel_irq_chk chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .int_status_out(int_status_out), .irq_pin_a_out(irq_pin_a_out),
  .irq_pin_a_oe_out(irq_pin_a_oe_out), .irq_pin_b_out(irq_pin_b_out), .irq_pin_b_oe_out(irq_pin_b_oe_out));

//--- sim/test_accel_irq_out_stage.sv
/* Self-checking bench of the interrupt output stage with a register shadow.
   Assumes the host model resolves both pins with pull-ups. */
`timescale 1ns/1ps
module test_accel_irq_out_stage
  import accel_irq_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic [7:0]    addr = 8'h00;
  logic [7:0]    wdata = 8'h00;
  accel_sample_t accel = '0;
  slope_sample_t slope = '0;
  ext_cfg_t      ecfg = '0;
  logic [7:0]    rdata;
  logic [3:0]    st;
  logic          pa, pa_oe, pb, pb_oe, la, lb;
  int            bad_count = 0;
  int            checks = 0;
  logic [7:0]    mem [8] = '{RST_PIN_CFG, RST_LATCH, RST_LOWG_DLY, RST_LOWG_LVL, RST_HYST_MODE,
                             RST_HIGHG_DLY, RST_HIGHG_LVL, RST_MOT_DUR};
  logic [7:0]    msk [8] = '{PIN_CFG_MASK, LATCH_MASK, 8'hFF, 8'hFF, HYST_MASK, 8'hFF, 8'hFF, 8'hFF};
  // Clock, 20 ns period
  always #10 clk = ~clk;
  accel_irq_out_stage #(.TICK_CYC(4)) dut (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .accel_in(accel), .slope_in(slope),
    .ext_cfg_in(ecfg), .reg_rdata_out(rdata), .int_status_out(st), .irq_pin_a_out(pa),
    .irq_pin_a_oe_out(pa_oe), .irq_pin_b_out(pb), .irq_pin_b_oe_out(pb_oe));
  accel_irq_host_model host (.pin_a_in(pa), .pin_a_oe_in(pa_oe), .pin_b_in(pb), .pin_b_oe_in(pb_oe),
    .level_a_out(la), .level_b_out(lb));
  // Compare, bus and stimulus tasks
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
    cmp_reg({6'h00, got}, {6'h00, exp});
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    if (a[7:3] == 5'h04) mem[a[2:0]] = d & msk[a[2:0]];
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp_reg(rdata, (a[7:3] == 5'h04) ? mem[a[2:0]] : 8'h00);
  endtask
  task automatic feed(input int b, input int n);
    repeat (n) begin
      @(posedge clk);
      accel <= {1'b1, 12'(b + $urandom % 64), 12'(b), 12'(b)};
    end
  endtask
  task automatic chk_st(input logic [3:0] e);
    @(posedge clk);
    #1 cmp_reg({4'h0, st}, {4'h0, e});
  endtask
  task automatic pins(input logic act);
    for (int c = 0; c < 16; c++) begin
      wr_reg(ADDR_PIN_CFG, c[7:0]);
      repeat (3) @(posedge clk);
      #1 cmp_pin({la, lb}, {act ~^ c[0], ~c[2]});
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h19405c89));
    ecfg.map_a <= 4'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 8'h1F; a < 8'h29; a++) rd_reg(a[7:0]);
    wr_reg(ADDR_LOWG_DLY, 8'h00);
    wr_reg(ADDR_LATCH, 8'h0F);
    feed(0, 24);
    chk_st(4'h0);
    feed(0, 36);
    chk_st(4'h1);
    feed(1000, 10);
    chk_st(4'h1);
    pins(1'b1);
    wr_reg(ADDR_LATCH, 8'h0F);
    chk_st(4'h1);
    wr_reg(ADDR_LATCH, 8'h8F);
    chk_st(4'h0);
    pins(1'b0);
    wr_reg(ADDR_LATCH, 8'h0E);
    feed(0, 60);
    chk_st(4'h1);
    feed(0, 840);
    chk_st(4'h0);
    wr_reg(ADDR_MOT_DUR, 8'h02);
    ecfg.anymot_axis_en <= 3'h1;
    ecfg.map_b <= 4'h4;
    @(posedge clk) slope <= {1'b1, 12'h001, 24'h000000};
    repeat (3) @(posedge clk);
    chk_st(4'h0);
    chk_st(4'h4);
    cmp_pin({la, lb}, 2'b01);
    wr_reg(ADDR_HIGHG_DLY, 8'h00);
    ecfg.highg_axis_en <= 3'h1;
    feed(1600, 60);
    chk_st(4'h6);
    for (int a = 0; a < 8; a++) begin
      wr_reg(8'h20 + a[7:0], 8'($urandom) & msk[a]);
      rd_reg(8'h20 + a[7:0]);
    end
    end_sim;
  end
  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim;
  end
endmodule
